// ### verilog/aic_defines.vh
// register map, field layout, reset values and timing constants for the input processor
`ifndef AIC_DEFINES_VH
`define AIC_DEFINES_VH
`define ADDR_INFO      12'h000
`define ADDR_IRQ_STAT  12'h004
`define ADDR_IRQ_CLR   12'h008
`define ADDR_IRQ_EN    12'h00C
`define ADDR_PEAK_RST  12'h010
`define CH_PAGE        4'h1
`define CH_OFFSET      5'h00
`define CH_GAIN        5'h04
`define CH_MODE        5'h08
`define CH_AVGN        5'h0C
`define CH_SLO         5'h10
`define CH_SHI         5'h14
`define CH_RESULT      5'h18
`define CH_PEAK        5'h1C
`define MODE_CURRENT   0
`define MODE_AVG       1
`define MODE_PEAK      2
`define MODE_DISC      3
`define MODE_SCALE     4
`define INFO_FOUR_WORD 0
`define INFO_BUSY      1
`define INFO_CAPTURED  2
`define RST_OFFSET     16'h03E8
`define RST_GAIN       16'h1388
`define RST_AVGN       14'h0002
`define RST_SLO        14'h0000
`define RST_SHI        14'h270F
`define FULL_CODE      12'hFFF
`define SPAN_MAX       16'h2710
`define RES_SPAN       17'h00FA0
`define DISC_MIN_GAIN  16'h03E8
`define AVG_MIN        14'h0002
`define AVG_MAX        14'h270F
`define BCD_MAX        15'h270F
`define DIV_STEPS      5'h1C
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define CLK_MHZ        25
`define CONV_TIME_US   10000
`define EXTRA_TIME_US  2000
`endif

// ### verilog/analog_input_conversion_processing.v
// eight-channel analog input post-processing with AXI4-Lite register access
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "aic_defines.vh"
module analog_input_conversion_processing #(
  parameter [19:0] CONV_LIMIT_CYC = `CONV_TIME_US * `CLK_MHZ,
  parameter [19:0] CONV_EXTRA_CYC = `EXTRA_TIME_US * `CLK_MHZ
) (
  input  wire               aclk,
  input  wire               aresetn,
  input  wire [11:0]        s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire [11:0]        s_axi_araddr,
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  input  wire               sample_valid,
  output wire               sample_ready,
  input  wire [2:0]         sample_chan,
  input  wire signed [15:0] sample_value,
  input  wire               four_word_sw,
  output wire               irq
);
  localparam NCH = 8;
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_MAP  = 6'b000010;
  localparam [5:0] ST_AVG  = 6'b000100;
  localparam [5:0] ST_CODE = 6'b001000;
  localparam [5:0] ST_SCL  = 6'b010000;
  localparam [5:0] ST_STOR = 6'b100000;

  // input units: 1 mV per count on voltage, 4 uA per count on current
  reg  [15:0] off_mem    [0:NCH-1];
  reg  [15:0] gain_mem   [0:NCH-1];
  reg  [4:0]  mode_mem   [0:NCH-1];
  reg  [13:0] avgn_mem   [0:NCH-1];
  reg  [13:0] slo_mem    [0:NCH-1];
  reg  [13:0] shi_mem    [0:NCH-1];
  reg  [15:0] result_mem [0:NCH-1];
  reg  [11:0] peak_mem   [0:NCH-1];
  reg  [25:0] sum_mem    [0:NCH-1];
  reg  [13:0] cnt_mem    [0:NCH-1];
  reg  [11:0] awaddr_reg;
  reg         aw_held_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         w_held_reg;
  reg  [8:0]  irq_en_reg;
  reg  [8:0]  irq_stat_reg;
  reg         sw_meta_reg;
  reg         sw_sync_reg;
  reg  [1:0]  cap_cnt_reg;
  reg         four_word_reg;
  reg  [5:0]  state_reg;
  reg  [2:0]  ch_reg;
  reg         fz_reg;
  reg         ff_reg;
  reg         lowres_reg;
  reg  [11:0] code_reg;
  reg  [15:0] out_reg;
  reg  [27:0] div_rem_reg;
  reg  [27:0] div_quo_reg;
  reg  [27:0] div_den_reg;
  reg  [4:0]  div_cnt_reg;
  reg  [19:0] tmo_reg;
  integer     i;

  function reg_known;
    input [11:0] a;
    begin
      reg_known = (a[11:8] == `CH_PAGE) || (a == `ADDR_INFO) || (a == `ADDR_IRQ_STAT) ||
                  (a == `ADDR_IRQ_CLR) || (a == `ADDR_IRQ_EN) || (a == `ADDR_PEAK_RST);
    end
  endfunction

  // write-only and unmapped words read as zero
  function [31:0] reg_read;
    input [11:0] a;
    begin
      reg_read = 32'h0000_0000;
      if (a[11:8] == `CH_PAGE) begin
        case (a[4:0])
          `CH_OFFSET: reg_read = {16'h0000, off_mem[a[7:5]]};
          `CH_GAIN:   reg_read = {16'h0000, gain_mem[a[7:5]]};
          `CH_MODE:   reg_read = {27'h0000000, mode_mem[a[7:5]]};
          `CH_AVGN:   reg_read = {18'h00000, avgn_mem[a[7:5]]};
          `CH_SLO:    reg_read = {18'h00000, slo_mem[a[7:5]]};
          `CH_SHI:    reg_read = {18'h00000, shi_mem[a[7:5]]};
          `CH_RESULT: reg_read = {16'h0000, result_mem[a[7:5]]};
          `CH_PEAK:   reg_read = {20'h00000, peak_mem[a[7:5]]};
          default:    reg_read = 32'h0000_0000;
        endcase
      end else if (a == `ADDR_INFO) begin
        reg_read = {29'h0000_0000, cap_cnt_reg == 2'h3, state_reg != ST_IDLE, four_word_reg};
      end else if (a == `ADDR_IRQ_STAT) begin
        reg_read = {23'h000000, irq_stat_reg};
      end else if (a == `ADDR_IRQ_EN) begin
        reg_read = {23'h000000, irq_en_reg};
      end
    end
  endfunction

  function [15:0] to_bcd;
    input [13:0] b;
    integer k;
    reg [29:0] s;
    begin
      s = {16'h0000, b};
      for (k = 0; k < 14; k = k + 1) begin
        if (s[17:14] > 4'h4) s[17:14] = s[17:14] + 4'h3;
        if (s[21:18] > 4'h4) s[21:18] = s[21:18] + 4'h3;
        if (s[25:22] > 4'h4) s[25:22] = s[25:22] + 4'h3;
        if (s[29:26] > 4'h4) s[29:26] = s[29:26] + 4'h3;
        s = {s[28:0], 1'b0};
      end
      to_bcd = s[29:14];
    end
  endfunction

  // register bus
  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready  = ~w_held_reg;
  assign s_axi_arready = ~s_axi_rvalid;
  wire        wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire        wr_ch   = awaddr_reg[11:8] == `CH_PAGE;
  wire [2:0]  wr_chan = awaddr_reg[7:5];
  wire [4:0]  wr_fld  = awaddr_reg[4:0];
  wire [31:0] wmask   = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}},
                         {8{wstrb_reg[0]}}};
  wire [31:0] wr_new  = (reg_read(awaddr_reg) & ~wmask) | (wdata_reg & wmask);
  wire [13:0] avgn_in = (wr_new[31:14] != 18'h0) ? `AVG_MAX : wr_new[13:0];
  wire [31:0] wr_pulse = wdata_reg & wmask;
  wire [7:0]  peak_rst = (wr_fire && awaddr_reg == `ADDR_PEAK_RST) ? wr_pulse[7:0] : 8'h00;
  wire [8:0]  irq_clr  = (wr_fire && awaddr_reg == `ADDR_IRQ_CLR) ? wr_pulse[8:0] : 9'h000;
  wire        acc_clr  = wr_fire & wr_ch & ((wr_fld == `CH_AVGN) | (wr_fld == `CH_MODE));

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= 12'h000;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      irq_en_reg   <= 9'h000;
      for (i = 0; i < NCH; i = i + 1) begin
        off_mem[i]  <= `RST_OFFSET;
        gain_mem[i] <= `RST_GAIN;
        mode_mem[i] <= 5'h00;
        avgn_mem[i] <= `RST_AVGN;
        slo_mem[i]  <= `RST_SLO;
        shi_mem[i]  <= `RST_SHI;
      end
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        awaddr_reg  <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
        w_held_reg <= 1'b1;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_known(awaddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_ch) begin
          case (wr_fld)
            `CH_OFFSET: off_mem[wr_chan]  <= wr_new[15:0];
            `CH_GAIN:   gain_mem[wr_chan] <= wr_new[15:0];
            `CH_MODE:   mode_mem[wr_chan] <= wr_new[4:0];
            `CH_AVGN:   avgn_mem[wr_chan] <= (avgn_in < `AVG_MIN) ? `AVG_MIN :
                                            (avgn_in > `AVG_MAX) ? `AVG_MAX : avgn_in;
            `CH_SLO:    slo_mem[wr_chan]  <= wr_new[13:0];
            `CH_SHI:    shi_mem[wr_chan]  <= wr_new[13:0];
            default:    ;
          endcase
        end else if (awaddr_reg == `ADDR_IRQ_EN) begin
          irq_en_reg <= wr_new[8:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= reg_read(s_axi_araddr);
        s_axi_rresp  <= reg_known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // allocation switch: synchronised, then caught once, on the third edge after reset release
  always @(posedge aclk) begin
    if (!aresetn) begin
      sw_meta_reg   <= 1'b0;
      sw_sync_reg   <= 1'b0;
      cap_cnt_reg   <= 2'h0;
      four_word_reg <= 1'b0;
    end else begin
      sw_meta_reg <= four_word_sw;
      sw_sync_reg <= sw_meta_reg;
      if (cap_cnt_reg != 2'h3) cap_cnt_reg <= cap_cnt_reg + 2'h1;
      if (cap_cnt_reg == 2'h2) four_word_reg <= sw_sync_reg;
    end
  end

  // sample front end
  assign sample_ready = state_reg == ST_IDLE;
  wire               accept = sample_valid & sample_ready;
  wire [15:0]        m_off  = off_mem[sample_chan];
  wire [15:0]        m_gain = gain_mem[sample_chan];
  wire [4:0]         m_mode = mode_mem[sample_chan];
  wire signed [17:0] m_diff = $signed({{2{sample_value[15]}}, sample_value}) -
                              $signed({2'b00, m_off});
  wire signed [17:0] m_span = $signed({2'b00, m_gain}) - $signed({2'b00, m_off});
  wire               m_cur  = m_mode[`MODE_CURRENT];
  wire               m_fz   = (~m_cur & (m_off > `SPAN_MAX)) | (m_diff <= 18'sd0) |
                              (m_cur & sample_value[15]);
  wire               m_ff   = (~m_cur & (m_gain > `SPAN_MAX)) | (m_span <= 18'sd0);
  wire [26:0]        m_num  = m_diff[14:0] * `FULL_CODE;
  wire signed [17:0] m_x2   = {sample_value[15], sample_value, 1'b0};
  wire               disc_evt = accept & m_mode[`MODE_DISC] & (m_gain >= `DISC_MIN_GAIN) &
                                (m_x2 <= $signed({2'b00, m_off}));
  wire [7:0]         disc_vec = disc_evt ? (8'h01 << sample_chan) : 8'h00;

  // shared restoring divider, one quotient bit per cycle
  wire [28:0] d_sh  = {div_rem_reg, div_quo_reg[27]};
  wire        d_ge  = d_sh >= {1'b0, div_den_reg};
  wire [28:0] d_sub = d_sh - {1'b0, div_den_reg};

  // current input above 20 mA is not forced; it only saturates at the code width
  wire [11:0] map_raw  = fz_reg ? 12'h000 : ff_reg ? `FULL_CODE :
                         (div_quo_reg > {16'h0000, `FULL_CODE}) ? `FULL_CODE : div_quo_reg[11:0];
  wire [11:0] map_code = {map_raw[11:1], map_raw[0] & ~lowres_reg};
  wire [4:0]  c_mode   = mode_mem[ch_reg];
  wire [13:0] c_cnt1   = cnt_mem[ch_reg] + 14'h0001;
  wire [13:0] s_span   = (shi_mem[ch_reg] > slo_mem[ch_reg]) ?
                         shi_mem[ch_reg] - slo_mem[ch_reg] : 14'h0000;
  wire [25:0] s_num    = code_reg * s_span;
  wire [14:0] s_val    = {1'b0, slo_mem[ch_reg]} + {1'b0, div_quo_reg[13:0]};
  wire [14:0] s_clip   = (s_val > `BCD_MAX) ? `BCD_MAX : s_val;
  wire        scale_on = c_mode[`MODE_SCALE] & ~four_word_reg;
  wire [3:0]  opts     = c_mode[4:1];
  wire        multi    = |(opts & (opts - 4'h1));
  wire [19:0] tmo_lim  = multi ? CONV_LIMIT_CYC + CONV_EXTRA_CYC : CONV_LIMIT_CYC;
  wire        ovr_evt  = (state_reg != ST_IDLE) & (tmo_reg == tmo_lim);

  // status: a new event wins over a clear in the same cycle
  assign irq = |(irq_stat_reg & irq_en_reg);

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg    <= ST_IDLE;
      ch_reg       <= 3'h0;
      fz_reg       <= 1'b0;
      ff_reg       <= 1'b0;
      lowres_reg   <= 1'b0;
      code_reg     <= 12'h000;
      out_reg      <= 16'h0000;
      div_rem_reg  <= 28'h0000000;
      div_quo_reg  <= 28'h0000000;
      div_den_reg  <= 28'h0000000;
      div_cnt_reg  <= 5'h00;
      tmo_reg      <= 20'h00000;
      irq_stat_reg <= 9'h000;
      for (i = 0; i < NCH; i = i + 1) begin
        result_mem[i] <= 16'h0000;
        peak_mem[i]   <= 12'h000;
        sum_mem[i]    <= 26'h0000000;
        cnt_mem[i]    <= 14'h0000;
      end
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | {ovr_evt, disc_vec};
      tmo_reg      <= (state_reg == ST_IDLE) ? 20'h00000 : tmo_reg + 20'h00001;
      for (i = 0; i < NCH; i = i + 1) begin
        if (peak_rst[i]) peak_mem[i] <= 12'h000;
      end
      if (acc_clr) begin
        sum_mem[wr_chan] <= 26'h0000000;
        cnt_mem[wr_chan] <= 14'h0000;
      end
      if (div_cnt_reg != 5'h00) begin
        div_rem_reg <= d_ge ? d_sub[27:0] : d_sh[27:0];
        div_quo_reg <= {div_quo_reg[26:0], d_ge};
        div_cnt_reg <= div_cnt_reg - 5'h01;
      end else begin
        case (state_reg)
          ST_IDLE: if (accept) begin
            ch_reg      <= sample_chan;
            fz_reg      <= m_fz;
            ff_reg      <= m_ff;
            lowres_reg  <= m_span < $signed({1'b0, `RES_SPAN});
            div_rem_reg <= 28'h0000000;
            div_quo_reg <= {1'b0, m_num};
            div_den_reg <= {10'h000, m_span};
            div_cnt_reg <= `DIV_STEPS;
            state_reg   <= ST_MAP;
          end
          ST_MAP: if (c_mode[`MODE_AVG] && !acc_clr) begin
            if (c_cnt1 >= avgn_mem[ch_reg]) begin
              div_rem_reg     <= 28'h0000000;
              div_quo_reg     <= {2'b00, sum_mem[ch_reg] + {14'h0000, map_code}};
              div_den_reg     <= {14'h0000, avgn_mem[ch_reg]};
              div_cnt_reg     <= `DIV_STEPS;
              sum_mem[ch_reg] <= 26'h0000000;
              cnt_mem[ch_reg] <= 14'h0000;
              state_reg       <= ST_AVG;
            end else begin
              sum_mem[ch_reg] <= sum_mem[ch_reg] + {14'h0000, map_code};
              cnt_mem[ch_reg] <= c_cnt1;
              state_reg       <= ST_IDLE;
            end
          end else begin
            code_reg  <= map_code;
            state_reg <= ST_CODE;
          end
          ST_AVG: begin
            code_reg  <= div_quo_reg[11:0];
            state_reg <= ST_CODE;
          end
          ST_CODE: if (scale_on) begin
            div_rem_reg <= 28'h0000000;
            div_quo_reg <= {2'b00, s_num};
            div_den_reg <= {16'h0000, `FULL_CODE};
            div_cnt_reg <= `DIV_STEPS;
            state_reg   <= ST_SCL;
          end else begin
            out_reg   <= {4'h0, code_reg};
            state_reg <= ST_STOR;
          end
          ST_SCL: begin
            out_reg   <= to_bcd(s_clip[13:0]);
            state_reg <= ST_STOR;
          end
          ST_STOR: begin
            result_mem[ch_reg] <= out_reg;
            if (c_mode[`MODE_PEAK] && (peak_rst[ch_reg] || code_reg > peak_mem[ch_reg]))
              peak_mem[ch_reg] <= code_reg;
            state_reg <= ST_IDLE;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/aic_checker.sv
// assertion checker for the analog input processor ports
`timescale 1ns/1ns
`default_nettype none
module aic_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence sample_taken; sample_valid && sample_ready; endsequence
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not retired");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not retired");
  ready_drop_a: assert property ($fell(sample_ready) |-> $past(sample_valid))
    else $error("processor went busy without a sample");
  sample_busy_a: assert property (sample_taken |=> !sample_ready [*8])
    else $error("processor ready too soon");
  sample_bound_a: assert property (sample_taken |-> ##[2:200] sample_ready)
    else $error("conversion overran its time");
  // flags other than the overrun flag move only on a sample take or a register write
  irq_rise_a: assert property (
    $rose(irq) |-> $past(sample_valid && sample_ready) || s_axi_bvalid)
    else $error("interrupt rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> s_axi_bvalid)
    else $error("interrupt fell without a write");
endmodule
bind analog_input_conversion_processing aic_checker i_aic_checker (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .sample_valid, .sample_ready, .irq);
`default_nettype wire

// ### tb/host_bus_model.sv
// register bus master standing in for the controller cpu
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  input  wire logic        aclk,
  output logic [11:0]      s_axi_awaddr = 12'h000,
  output logic             s_axi_awvalid = 1'b0,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata = 32'h00000000,
  output logic [3:0]       s_axi_wstrb = 4'hF,
  output logic             s_axi_wvalid = 1'b0,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready = 1'b0,
  output logic [11:0]      s_axi_araddr = 12'h000,
  output logic             s_axi_arvalid = 1'b0,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready = 1'b0
);
  // peak reset and other host commands go out as plain writes
  task automatic write_word(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // released data must not look like the last word
    s_axi_wdata  <= ~d;
  endtask
  task automatic read_word(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/analog_input_conversion_processing_tb_top.sv
// self-checking bench for the analog input processor
`timescale 1ns/1ns
`default_nettype none
`include "aic_defines.vh"
module analog_input_conversion_processing_tb_top;
  logic               aclk = 1'b0;
  logic               aresetn = 1'b0;
  logic               sample_valid = 1'b0;
  logic [2:0]         sample_chan = 3'h0;
  logic signed [15:0] sample_value = 16'h0000;
  logic               four_word_sw = 1'b0;
  wire logic [11:0]   s_axi_awaddr, s_axi_araddr;
  wire logic [31:0]   s_axi_wdata, s_axi_rdata;
  wire logic [3:0]    s_axi_wstrb;
  wire logic [1:0]    s_axi_bresp, s_axi_rresp;
  wire logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  wire logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  wire logic          s_axi_rvalid, s_axi_rready, sample_ready, irq;
  logic [31:0]        rd;
  logic [1:0]         rs;
  int                 fail_count = 0;
  int                 num_checks = 0;
  always #20 aclk = ~aclk;
  // short time limits still exceed the longest conversion, so the overrun flag stays clear in simulation
  analog_input_conversion_processing #(.CONV_LIMIT_CYC(20'h000C8), .CONV_EXTRA_CYC(20'h00032))
    i_analog_input_conversion_processing (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_valid, .sample_ready, .sample_chan,
    .sample_value, .four_word_sw, .irq);
  host_bus_model i_host_bus_model (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [11:0] cadr(input logic [2:0] ch, input logic [4:0] off);
    cadr = {`CH_PAGE, ch, off};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host_bus_model.write_word(a, d, rs);
  endtask
  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    i_host_bus_model.read_word(a, rd, rs);
    chk(what, exp, rd);
  endtask
  task automatic smp(input logic [2:0] ch, input logic [15:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    sample_chan  <= ch;
    sample_value <= v;
    sample_valid <= 1'b1;
    do @(posedge aclk); while (!sample_ready);
    sample_valid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!sample_ready && n < 300);
    chk("sample done", 32'h1, {31'h0, sample_ready});
  endtask
  task automatic conv(input string what, input logic [2:0] ch, input logic [15:0] v,
                      input logic [4:0] off, input logic [31:0] exp);
    smp(ch, v);
    rchk(what, cadr(ch, off), exp);
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask
  task automatic t_regs;
    rchk("offset", cadr(3'h3, `CH_OFFSET), 32'h000003E8);
    rchk("gain", cadr(3'h3, `CH_GAIN), 32'h00001388);
    rchk("info", `ADDR_INFO, 32'h00000004);
    i_host_bus_model.read_word(12'h800, rd, rs);
    chk("unmapped resp", 32'h2, {30'h0, rs});
    wr(cadr(3'h3, `CH_AVGN), 32'h00000001);
    rchk("avg count", cadr(3'h3, `CH_AVGN), 32'h00000002);
  endtask
  task automatic t_convert;
    conv("at offset", 3'h1, 16'h03E8, `CH_RESULT, 32'h0);
    conv("at gain", 3'h1, 16'h1388, `CH_RESULT, 32'hFFF);
    conv("below offset", 3'h1, 16'h01F4, `CH_RESULT, 32'h0);
    wr(cadr(3'h2, `CH_OFFSET), 32'h00002711);
    conv("offset lock", 3'h2, 16'h1388, `CH_RESULT, 32'h0);
    wr(cadr(3'h2, `CH_OFFSET), 32'h000003E8);
    wr(cadr(3'h2, `CH_GAIN), 32'h00002711);
    conv("gain lock", 3'h2, 16'h0BB8, `CH_RESULT, 32'hFFF);
    wr(cadr(3'h3, `CH_MODE), 32'h00000001);
    conv("negative current", 3'h3, 16'hFF9C, `CH_RESULT, 32'h0);
    conv("over current", 3'h3, 16'h1770, `CH_RESULT, 32'hFFF);
    // a 2 V span loses the lowest code bit
    wr(cadr(3'h0, `CH_GAIN), 32'h00000BB8);
    conv("low resolution", 3'h0, 16'h0BB8, `CH_RESULT, 32'hFFE);
  endtask
  task automatic t_avg;
    conv("avg start", 3'h4, 16'h03E8, `CH_RESULT, 32'h0);
    wr(cadr(3'h4, `CH_MODE), 32'h00000002);
    conv("avg partial", 3'h4, 16'h1388, `CH_RESULT, 32'h0);
    conv("avg full", 3'h4, 16'h1388, `CH_RESULT, 32'hFFF);
  endtask
  task automatic t_peak;
    wr(cadr(3'h5, `CH_MODE), 32'h00000004);
    conv("peak high", 3'h5, 16'h1388, `CH_PEAK, 32'hFFF);
    conv("peak kept", 3'h5, 16'h03E8, `CH_PEAK, 32'hFFF);
    wr(`ADDR_PEAK_RST, 32'h00000020);
    conv("peak restart", 3'h5, 16'h03E8, `CH_PEAK, 32'h0);
  endtask
  task automatic t_open;
    wr(`ADDR_IRQ_EN, 32'h00000040);
    wr(cadr(3'h6, `CH_MODE), 32'h00000008);
    conv("open lead", 3'h6, 16'h01F4, 5'h18, 32'h0);
    rchk("flag set", `ADDR_IRQ_STAT, 32'h00000040);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(`ADDR_IRQ_CLR, 32'h00000040);
    chk("irq cleared", 32'h0, {31'h0, irq});
    smp(3'h6, 16'h01F5);
    rchk("just above", `ADDR_IRQ_STAT, 32'h0);
    wr(cadr(3'h6, `CH_OFFSET), 32'h00000190);
    wr(cadr(3'h6, `CH_GAIN), 32'h00000384);
    smp(3'h6, 16'h0064);
    rchk("low gain", `ADDR_IRQ_STAT, 32'h0);
  endtask
  task automatic t_scale;
    wr(cadr(3'h7, `CH_MODE), 32'h00000010);
    conv("bcd full", 3'h7, 16'h1388, `CH_RESULT, 32'h9999);
    conv("bcd zero", 3'h7, 16'h03E8, `CH_RESULT, 32'h0);
    wr(cadr(3'h7, `CH_SHI), 32'h00001388);
    conv("bcd scaled", 3'h7, 16'h1388, `CH_RESULT, 32'h5000);
    four_word_sw <= 1'b1;
    do_reset;
    rchk("four word", `ADDR_INFO, 32'h00000005);
    wr(cadr(3'h7, `CH_MODE), 32'h00000010);
    conv("no bcd", 3'h7, 16'h1388, `CH_RESULT, 32'hFFF);
  endtask
  initial begin
    do_reset;
    t_regs;
    t_convert;
    t_avg;
    t_peak;
    t_open;
    t_scale;
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
